// file: reset_cause_defines.vh
// Register offsets, field positions, reset values and event bits of the reset-cause block.
// Assumes inclusion by bare name; definitions only.
`ifndef RESET_CAUSE_DEFINES_VH
`define RESET_CAUSE_DEFINES_VH

`define RC_ADDR_W            8
`define RC_DATA_W            8
// Register offsets
`define RC_OFF_STATUS        8'h8e
`define RC_OFF_EVENT         8'h90
`define RC_OFF_MASK          8'h91
`define RC_OFF_CONFIG        8'h92
// Field positions in the cause register
`define RC_POWERON_BIT       1
`define RC_BROWNOUT_BIT      0
`define RC_FLAG_MASK         8'h03
// Event status bits
`define RC_EV_POWERON        0
`define RC_EV_BROWNOUT       1
`define RC_EV_WATCHDOG       2
`define RC_EV_EXTPIN         3
`define RC_EV_W              4
// Config field: brown-out detect enable at bit 0
`define RC_CFG_BOD_BIT       0
// Reset values
`define RC_MASK_RESET        4'h0
`define RC_CFG_RESET         1'b1
`define RC_BROWNOUT_POR      1'b1

`endif

// file: reset_cause_flag_cell.v
// One reset-cause flag: cleared by its own reset source, set or cleared by software.
// Assumes the cause pulses are synchronous one-cycle strobes on clk.
`timescale 1ns/1ps
module reset_cause_flag_cell #(
	parameter RESET_VAL = 1'b0
) (
	input  wire clk,
	input  wire rst_n,
	input  wire cause,
	input  wire wr_en,
	input  wire wr_val,
	output reg  flag
);

	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			flag <= RESET_VAL;
		end else if (cause) begin
			// Hardware cause wins over a simultaneous software write
			flag <= 1'b0;
		end else if (wr_en) begin
			flag <= wr_val;
		end
	end

endmodule

// file: reset_cause_flags.v
// Reset-cause status register with event interrupt and plain register port.
// Assumes cause inputs are one-cycle pulses synchronous to clk, raised by the reset controller
// as the matching reset ends; rst_n is the power-on reset of this block.
//
// Implementation choice: strobed register access.
`timescale 1ns/1ps
`include "reset_cause_defines.vh"

// Summary of operation
// [RULE_01] Cause register lets software tell power-on, brown-out, watchdog and pin resets.
// [RULE_02] Bit 1 power-on flag: cleared by power-on reset, writable by software.
// [RULE_03] Bit 0 brown-out flag: cleared by brown-out reset, writable by software.
// [RULE_04] Brown-out flag undefined after power-on; software sets it, checks later.
// [RULE_05] With brown-out detect disabled the brown-out flag carries no meaning.
// [RULE_06] Bits 7 to 2 read zero and ignore writes.
// [RULE_07] Watchdog and pin resets leave both flags unchanged.
module reset_cause_flags (
	input  wire       clk,
	input  wire       rst_n,
	input  wire       poweron_event,
	input  wire       brownout_event,
	input  wire       watchdog_event,
	input  wire       external_reset_pin,
	input  wire [7:0] addr,
	input  wire [7:0] wdata,
	input  wire       wr,
	input  wire       rd,
	output reg  [7:0] rdata,
	output reg        irq,
	output reg        brownout_detect_enable
);

	// ----------------------------------------
	// Reset release
	// ----------------------------------------
	reg rst_meta;
	reg rst_sync_n;

	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			rst_meta   <= 1'b0;
			rst_sync_n <= 1'b0;
		end else begin
			rst_meta   <= 1'b1;
			rst_sync_n <= rst_meta;
		end
	end

	// ----------------------------------------
	// Decode
	// ----------------------------------------
	function hit;
		input [7:0] a;
		input [7:0] off;
		begin
			hit = (a == off);
		end
	endfunction

	wire wr_status = wr && hit(addr, `RC_OFF_STATUS);
	wire wr_event  = wr && hit(addr, `RC_OFF_EVENT);
	wire wr_mask   = wr && hit(addr, `RC_OFF_MASK);
	wire wr_config = wr && hit(addr, `RC_OFF_CONFIG);

	// ----------------------------------------
	// Cause flags
	// ----------------------------------------
	wire poweron_flag;
	wire brownout_flag;

	// [RULE_02] power-on clears flag
	reset_cause_flag_cell #(
		.RESET_VAL (1'b0)
	) u_poweron (
		.clk    (clk),
		.rst_n  (rst_sync_n),
		.cause  (poweron_event),
		.wr_en  (wr_status),
		.wr_val (wdata[`RC_POWERON_BIT]),
		.flag   (poweron_flag)
	);

	// [RULE_03] brown-out clears flag
	// [RULE_04] loads RC_BROWNOUT_POR (1) after power-on
	// [RULE_05] ignores detect enable
	reset_cause_flag_cell #(
		.RESET_VAL (`RC_BROWNOUT_POR)
	) u_brownout (
		.clk    (clk),
		.rst_n  (rst_sync_n),
		.cause  (brownout_event),
		.wr_en  (wr_status),
		.wr_val (wdata[`RC_BROWNOUT_BIT]),
		.flag   (brownout_flag)
	);

	// [RULE_07] no flag path for watchdog or pin
	// The watchdog and pin causes feed only the event register below.

	// ----------------------------------------
	// Event inputs
	// ----------------------------------------
	reg [3:0] ev_in;
	reg [3:0] ev_clear;

	// Gather the four causes at their event bit positions
	always @* begin
		ev_in                  = 4'h0;
		ev_in[`RC_EV_POWERON]  = poweron_event;
		ev_in[`RC_EV_BROWNOUT] = brownout_event;
		ev_in[`RC_EV_WATCHDOG] = watchdog_event;
		ev_in[`RC_EV_EXTPIN]   = external_reset_pin;
	end

	// Bits written as one clear their event; zeros leave it alone
	always @* begin
		ev_clear = 4'h0;
		if (wr_event) begin
			ev_clear = wdata[3:0];
		end
	end

	// ----------------------------------------
	// Event status
	// ----------------------------------------
	reg [3:0] event_status;
	reg [3:0] next_event_status;

	// [RULE_01] sticky cause events
	// A cause arriving in the same cycle as its clear survives it
	always @* begin
		next_event_status = (event_status & ~ev_clear) | ev_in;
	end

	always @(posedge clk or negedge rst_sync_n) begin
		if (!rst_sync_n) begin
			event_status <= 4'h0;
		end else begin
			event_status <= next_event_status;
		end
	end

	// ----------------------------------------
	// Event mask
	// ----------------------------------------
	reg [3:0] event_mask;
	reg [3:0] next_event_mask;

	always @* begin
		next_event_mask = event_mask;
		if (wr_mask) begin
			next_event_mask = wdata[3:0];
		end
	end

	always @(posedge clk or negedge rst_sync_n) begin
		if (!rst_sync_n) begin
			event_mask <= `RC_MASK_RESET;
		end else begin
			event_mask <= next_event_mask;
		end
	end

	// ----------------------------------------
	// Configuration
	// ----------------------------------------
	reg next_detect_enable;

	// [RULE_05] enable reported only
	always @* begin
		next_detect_enable = brownout_detect_enable;
		if (wr_config) begin
			next_detect_enable = wdata[`RC_CFG_BOD_BIT];
		end
	end

	always @(posedge clk or negedge rst_sync_n) begin
		if (!rst_sync_n) begin
			brownout_detect_enable <= `RC_CFG_RESET;
		end else begin
			brownout_detect_enable <= next_detect_enable;
		end
	end

	// ----------------------------------------
	// Interrupt
	// ----------------------------------------
	reg next_irq;

	// Built from the values the registers take at this edge, so a mask write or a clear
	// shows on irq in the same cycle as in the registers themselves
	always @* begin
		next_irq = |(next_event_status & next_event_mask);
	end

	always @(posedge clk or negedge rst_sync_n) begin
		if (!rst_sync_n) begin
			irq <= 1'b0;
		end else begin
			irq <= next_irq;
		end
	end

	// ----------------------------------------
	// Read port
	// ----------------------------------------
	reg [7:0] status_word;
	reg [7:0] next_rdata;

	// [RULE_06] upper bits read zero
	always @* begin
		status_word                   = 8'h00;
		status_word[`RC_POWERON_BIT]  = poweron_flag;
		status_word[`RC_BROWNOUT_BIT] = brownout_flag;
	end

	// Unmapped addresses read as zero
	always @* begin
		next_rdata = 8'h00;
		case (addr)
			`RC_OFF_STATUS: next_rdata = status_word & `RC_FLAG_MASK;
			`RC_OFF_EVENT:  next_rdata = {4'h0, event_status};
			`RC_OFF_MASK:   next_rdata = {4'h0, event_mask};
			`RC_OFF_CONFIG: next_rdata = {7'h00, brownout_detect_enable};
			default:        next_rdata = 8'h00;
		endcase
	end

	// Read data stand for the one cycle after the strobe and are zero otherwise
	always @(posedge clk or negedge rst_sync_n) begin
		if (!rst_sync_n) begin
			rdata <= 8'h00;
		end else if (rd) begin
			rdata <= next_rdata;
		end else begin
			rdata <= 8'h00;
		end
	end

endmodule

// file: reset_cause_flags_assertions.sv
// Reset-cause port checker.
// Bound to the top module; one clock.
`timescale 1ns/1ps
module reset_cause_flags_assertions (
	input wire       clk,
	input wire       rst_n,
	input wire       poweron_event,
	input wire       brownout_event,
	input wire       watchdog_event,
	input wire       external_reset_pin,
	input wire [7:0] addr,
	input wire [7:0] wdata,
	input wire       wr,
	input wire       rd,
	input wire [7:0] rdata,
	input wire       irq,
	input wire       brownout_detect_enable
);
	default clocking @(posedge clk);
	endclocking
	default disable iff (!rst_n);
	wire       q = !poweron_event && !brownout_event;
	wire       n = q && !watchdog_event && !external_reset_pin;
	wire [1:0] f = wdata[1:0];
	sequence s_rd;
		rd && addr == 8'h8e;
	endsequence
	a_upper_zero: assert property (!rd || addr == 8'h8e |=> rdata[7:2] == 6'h00)
		else $error("upper");
	a_write_back: assert property (wr && addr == 8'h8e && q ##1 s_rd |=> rdata[1:0] == $past(f, 2))
		else $error("write");
	a_brownout_clear: assert property (brownout_event ##1 s_rd |=> !rdata[0])
		else $error("brownout flag not cleared");
	a_poweron_clear: assert property (poweron_event ##1 s_rd |=> !rdata[1])
		else $error("power-on flag not cleared");
	a_config_read: assert property (rd && addr == 8'h92 |=> rdata == {7'h00, $past(brownout_detect_enable)})
		else $error("config read wrong");
	a_cause_kept: assert property (s_rd ##0 q && !n ##1 s_rd |=> $stable(rdata))
		else $error("kept");
	a_irq_clear: assert property (wr && addr == 8'h90 && wdata[3:0] == 4'hf && n |=> !irq)
		else $error("irq");
endmodule
bind reset_cause_flags reset_cause_flags_assertions chk_u (.*);

// file: tb_reset_cause_flags.sv
// Bench: random traffic against a model.
// Assumes the design and checker.
`timescale 1ns/1ps
module tb_reset_cause_flags;
	logic        clk, rst_n, wr, rd;
	logic [3:0]  e;
	logic [7:0]  addr, wdata, fl, ev, mk, er, cf;
	logic [31:0] x;
	wire  [7:0]  rdata;
	wire         irq, brownout_detect_enable;
	int          num_errors, total_checks;
	reset_cause_flags dut_u (.*, .poweron_event(e[0]), .brownout_event(e[1]), .watchdog_event(e[2]),
		.external_reset_pin(e[3]));
	function [31:0] xs(input [31:0] v);
		v = v ^ (v << 13);
		v = v ^ (v >> 17);
		xs = v ^ (v << 5);
	endfunction
	task chk(input [7:0] g, w);
		total_checks++;
		if (g !== w) begin
			num_errors++;
			$display("Error %0t: %h not %h", $time, g, w);
		end
	endtask
	task stop_test;
		$display("checks %0d errors %0d", total_checks, num_errors);
		if (num_errors == 0 && total_checks > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	task cyc(input [3:0] c, input w, r, input [7:0] a, d);
		@(posedge clk);
		{e, wr, rd, addr, wdata} <= {c, w, r, a, d};
		#1;
		chk(rdata, er);
		chk(8'(irq), 8'(|(ev & mk)));
		chk(8'(brownout_detect_enable), cf);
		er = !r ? 8'h00 : a == 8'h8e ? fl : a == 8'h90 ? ev : a == 8'h91 ? mk : a == 8'h92 ? cf : 8'h00;
		if (w && a == 8'h92)
			cf = d & 8'h01;
		if (w && a == 8'h8e)
			fl = d & 8'h03;
		if (w && a == 8'h91)
			mk = d & 8'h0f;
		if (w && a == 8'h90)
			ev = ev & ~d;
		fl = fl & ~{6'h0, c[0], c[1]};
		ev = ev | c;
	endtask
	initial begin
		clk = 0;
		forever #4 clk = ~clk;
	end
	initial begin
		#9000;
		num_errors++;
		stop_test;
	end
	initial begin
		{rst_n, e, wr, rd, addr, wdata, fl, ev, mk, er} = 0;
		x = 32'h7441;
		cf = 8'h01;
		repeat (20) @(posedge clk);
		rst_n <= 1;
		repeat (2) @(posedge clk);
		cyc(0, 1, 0, 8'h8e, 8'hff);
		cyc(4'h4, 0, 1, 8'h8e, 0);
		cyc(4'h8, 0, 1, 8'h8e, 0);
		cyc(4'h2, 0, 1, 8'h8e, 0);
		cyc(4'h1, 0, 1, 8'h8e, 0);
		cyc(0, 1, 0, 8'h91, 8'hff);
		cyc(0, 1, 0, 8'h90, 8'h0f);
		$display("directed done");
		repeat (400) begin
			x = xs(x);
			cyc(x[7:4] & x[11:8] & x[15:12], x[16], !x[16] & x[17], 8'h8e + x[19:18], x[31:24]);
		end
		cyc(0, 0, 0, 0, 0);
		chk(8'(brownout_detect_enable), 8'h01);
		$display("random done");
		cyc(0, 1, 0, 8'h92, 8'h00);
		cyc(0, 0, 1, 8'h92, 8'h00);
		cyc(0, 1, 0, 8'h8e, 8'hff);
		cyc(4'h1, 0, 0, 8'h8e, 8'h00);
		cyc(0, 0, 1, 8'h8e, 8'h00);
		cyc(0, 0, 0, 0, 0);
		@(posedge clk);
		rst_n <= 1'b0;
		repeat (3) @(posedge clk);
		rst_n <= 1'b1;
		repeat (3) @(posedge clk);
		{rd, addr} <= {1'b1, 8'h8e};
		@(posedge clk);
		rd <= 1'b0;
		#1;
		chk(rdata & 8'h02, 8'h00);
		chk(8'(irq), 8'h00);
		chk(8'(brownout_detect_enable), 8'h01);
		{ev, mk, er} = 0;
		cf = 8'h01;
		cyc(0, 1, 0, 8'h8e, 8'h03);
		cyc(0, 0, 1, 8'h8e, 8'h00);
		cyc(0, 0, 0, 0, 0);
		$display("reset done");
		stop_test;
	end
endmodule
